// >>> rtl/qd_cfg.svh
// register offsets, field positions, reset values and timing counts of the quadrature decoder
`ifndef QD_CFG_SVH
`define QD_CFG_SVH

// -----------------------------------------------------------------------------
// byte offsets on the register bus
// -----------------------------------------------------------------------------
`define QD_OFS_FILTER_EN     8'h00
`define QD_OFS_MASK_LOW      8'h04
`define QD_OFS_MASK_HIGH     8'h08
`define QD_OFS_START_TRIG    8'h0C
`define QD_OFS_FLAG_LOW      8'h10
`define QD_OFS_FLAG_HIGH     8'h14
`define QD_OFS_CHAN_STATUS   8'h18
`define QD_OFS_POSITION      8'h1C
`define QD_OFS_EDGE_SELECT   8'h20

// -----------------------------------------------------------------------------
// field positions
// -----------------------------------------------------------------------------
`define QD_BIT_CHAN0_MASK    7
`define QD_BIT_CHAN1_MASK    0
`define QD_BIT_CHAN0_FLAG    7
`define QD_BIT_CHAN1_FLAG    0
`define QD_HIGH_FIXED_ONES   8'hF8

// -----------------------------------------------------------------------------
// reset values
// -----------------------------------------------------------------------------
`define QD_RST_FILTER_EN     2'h3
`define QD_RST_MASK          1'h1
`define QD_RST_EDGE_SELECT   4'hA

// -----------------------------------------------------------------------------
// timing: samples a filtered input must hold before it is accepted
// -----------------------------------------------------------------------------
`define QD_FILTER_SAMPLES    3

`endif

// >>> rtl/qd_noise_filter.sv
// switchable noise filter for one encoder input pin
`timescale 1ns/10ps
`include "qd_cfg.svh"

module qd_noise_filter
#(
    parameter int SAMPLES = `QD_FILTER_SAMPLES
)
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic pin_in,
    input  wire logic pin_filter_on,
    output      logic pin_out
);

    localparam int CW = $clog2(SAMPLES + 1);

    logic [CW-1:0] run_ff;
    logic [CW-1:0] nxt_run;
    logic          out_ff;
    logic          nxt_out;

    // -------------------------------------------------------------------------
    // filter
    // -------------------------------------------------------------------------
    // a change is taken only after SAMPLES equal samples; glitches shorter
    // than that never reach the edge logic
    always_comb
    begin
        nxt_run = run_ff;
        nxt_out = out_ff;
        if (!pin_filter_on)
        begin
            nxt_run = '0;
            nxt_out = pin_in;
        end
        else if (pin_in == out_ff)
        begin
            nxt_run = '0;
        end
        else if (run_ff == CW'(SAMPLES - 1))
        begin
            nxt_run = '0;
            nxt_out = pin_in;
        end
        else
        begin
            nxt_run = run_ff + CW'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            run_ff <= '0;
            out_ff <= 1'b0;
        end
        else
        begin
            run_ff <= nxt_run;
            out_ff <= nxt_out;
        end
    end

    assign pin_out = out_ff;

    a_filter_bypass: assert property (@(posedge pclk) disable iff (!presetn)
        !pin_filter_on |=> pin_out == $past(pin_in))
        else $error("unfiltered pin does not follow its input");

    a_filter_hold: assert property (@(posedge pclk) disable iff (!presetn)
        pin_filter_on && $past(pin_filter_on) && (pin_in != pin_out) && (run_ff == '0)
        |=> pin_out == $past(pin_out))
        else $error("filtered pin changed on a single sample");

endmodule

// >>> rtl/qd_pkg.sv
// types shared by the quadrature decoder files
package qd_pkg;

    // -------------------------------------------------------------------------
    // action chosen for one encoder edge
    // -------------------------------------------------------------------------
    typedef enum logic [1:0]
    {
        QD_ACT_NONE = 2'h0,
        QD_ACT_UP   = 2'h1,
        QD_ACT_DOWN = 2'h3
    } qd_act_e;

endpackage

// >>> rtl/qd_quad_decoder.sv
// two-phase quadrature decoder with apb registers and edge interrupts
// -----------------------------------------------------------------------------
// Functional notes
// - each encoder pin passes through a noise filter when its filter bit is 1, raw when 0.
// - channel 0 mask is bit 7 of the low mask register, channel 1 bit 0 of the high; 1 blocks.
// - writing 1 to start-trigger bit 0 or 1 enables that channel; writing 0 does nothing.
// - channel 0 flag is bit 7 of the low flag register, channel 1 bit 0 of the high one.
// - with both phases low, a rise on A counts down and a rise on B counts up.
// - with A high and B low, a fall on A counts up and a rise on B counts down.
// - with A low and B high, a rise on A counts up and a fall on B counts down.
// - with both phases high, a fall on A counts down and a fall on B counts up.
// - the step comes from an eight-entry table indexed by prior levels and moved phase.
// - each channel detects both edges with edge-select codes 10 and 11.
// -----------------------------------------------------------------------------
`timescale 1ns/10ps
`include "qd_cfg.svh"

module qd_quad_decoder
#(
    parameter int POS_W   = 16,
    parameter int SAMPLES = `QD_FILTER_SAMPLES
)
(
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output      logic [31:0]      prdata,
    output      logic             pready,
    output      logic             pslverr,
    input  wire logic [1:0]       encoder_input_pin,
    output      logic             chan0_edge_irq,
    output      logic             chan1_edge_irq,
    output      logic             step_increment,
    output      logic             step_decrement,
    output      logic [POS_W-1:0] position,
    output      logic             irq
);

    // -------------------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------------------
    // entry k of the table sits at offset k; index is {prev b, prev a, b moved}
    function automatic qd_pkg::qd_act_e edge_action(input logic [2:0] idx);
        case (idx)
            3'h0:    edge_action = qd_pkg::QD_ACT_DOWN;
            3'h1:    edge_action = qd_pkg::QD_ACT_UP;
            3'h2:    edge_action = qd_pkg::QD_ACT_UP;
            3'h3:    edge_action = qd_pkg::QD_ACT_DOWN;
            3'h4:    edge_action = qd_pkg::QD_ACT_UP;
            3'h5:    edge_action = qd_pkg::QD_ACT_DOWN;
            3'h6:    edge_action = qd_pkg::QD_ACT_DOWN;
            default: edge_action = qd_pkg::QD_ACT_UP;
        endcase
    endfunction

    function automatic logic sel_edge(input logic [1:0] code, input logic rise,
                                      input logic fall);
        sel_edge = code[1] ? (rise | fall) : (code[0] ? rise : fall);
    endfunction

    // -------------------------------------------------------------------------
    // input filters
    // -------------------------------------------------------------------------
    logic [1:0] filt_en_ff;
    logic [1:0] phase;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_filt
            qd_noise_filter #(.SAMPLES(SAMPLES)) u_filt
            (
                .pclk          (pclk),
                .presetn       (presetn),
                .pin_in        (encoder_input_pin[gi]),
                .pin_filter_on (filt_en_ff[gi]),
                .pin_out       (phase[gi])
            );
        end
    endgenerate

    // -------------------------------------------------------------------------
    // bus decode
    // -------------------------------------------------------------------------
    logic wr_en;
    logic rd_setup;
    logic addr_ok;

    assign wr_en    = psel & penable & pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign addr_ok  = (paddr == `QD_OFS_FILTER_EN)  || (paddr == `QD_OFS_MASK_LOW)   ||
                      (paddr == `QD_OFS_MASK_HIGH)  || (paddr == `QD_OFS_START_TRIG) ||
                      (paddr == `QD_OFS_FLAG_LOW)   || (paddr == `QD_OFS_FLAG_HIGH)  ||
                      (paddr == `QD_OFS_CHAN_STATUS) || (paddr == `QD_OFS_POSITION)  ||
                      (paddr == `QD_OFS_EDGE_SELECT);
    // zero wait states: every access completes in its first access cycle
    assign pready   = 1'b1;
    assign pslverr  = psel & penable & ~addr_ok;

    // -------------------------------------------------------------------------
    // control registers
    // -------------------------------------------------------------------------
    logic [1:0] nxt_filt_en;
    logic       mask0_ff;
    logic       nxt_mask0;
    logic       mask1_ff;
    logic       nxt_mask1;
    logic [1:0] chan_en_ff;
    logic [1:0] nxt_chan_en;
    logic [3:0] edge_sel_ff;
    logic [3:0] nxt_edge_sel;
    logic       start_wr;

    assign start_wr = wr_en && (paddr == `QD_OFS_START_TRIG);

    always_comb
    begin
        nxt_filt_en  = filt_en_ff;
        nxt_mask0    = mask0_ff;
        nxt_mask1    = mask1_ff;
        nxt_edge_sel = edge_sel_ff;
        // a zero bit leaves its channel as it is
        nxt_chan_en  = chan_en_ff | (start_wr ? pwdata[1:0] : 2'h0);
        if (wr_en)
        begin
            case (paddr)
                `QD_OFS_FILTER_EN:   nxt_filt_en  = pwdata[1:0];
                `QD_OFS_MASK_LOW:    nxt_mask0    = pwdata[`QD_BIT_CHAN0_MASK];
                `QD_OFS_MASK_HIGH:   nxt_mask1    = pwdata[`QD_BIT_CHAN1_MASK];
                `QD_OFS_EDGE_SELECT: nxt_edge_sel = pwdata[3:0];
                default:             nxt_filt_en  = filt_en_ff;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            filt_en_ff  <= `QD_RST_FILTER_EN;
            mask0_ff    <= `QD_RST_MASK;
            mask1_ff    <= `QD_RST_MASK;
            chan_en_ff  <= 2'h0;
            edge_sel_ff <= `QD_RST_EDGE_SELECT;
        end
        else
        begin
            filt_en_ff  <= nxt_filt_en;
            mask0_ff    <= nxt_mask0;
            mask1_ff    <= nxt_mask1;
            chan_en_ff  <= nxt_chan_en;
            edge_sel_ff <= nxt_edge_sel;
        end
    end

    // -------------------------------------------------------------------------
    // edge detection and decoding
    // -------------------------------------------------------------------------
    logic [1:0]       lvl_ff;
    logic [1:0]       prev_ff;
    logic [1:0]       nxt_prev;
    logic [1:0]       det;
    logic [2:0]       tbl_idx;
    logic             tbl_hit;
    qd_pkg::qd_act_e  act;
    logic [POS_W-1:0] pos_ff;
    logic [POS_W-1:0] nxt_pos;
    logic             up_ff;
    logic             nxt_up;
    logic             dn_ff;
    logic             nxt_dn;

    for (gi = 0; gi < 2; gi++)
    begin : g_det
        assign det[gi] = chan_en_ff[gi] &
                         sel_edge(edge_sel_ff[2*gi +: 2], phase[gi] & ~lvl_ff[gi],
                                  ~phase[gi] & lvl_ff[gi]);
    end

    assign tbl_idx = {prev_ff[1], prev_ff[0], det[1]};
    // the moved phase must leave its stored level, otherwise no entry applies
    assign tbl_hit = (det == 2'h1) ? (phase[0] != prev_ff[0]) :
                     (det == 2'h2) ? (phase[1] != prev_ff[1]) : 1'b0;
    assign act     = tbl_hit ? edge_action(tbl_idx) : qd_pkg::QD_ACT_NONE;

    always_comb
    begin
        nxt_pos  = pos_ff;
        nxt_up   = 1'b0;
        nxt_dn   = 1'b0;
        nxt_prev = prev_ff;
        // edges on both phases in one cycle are not a legal step; they only resync
        if (start_wr || (det != 2'h0))
        begin
            nxt_prev = phase;
        end
        case (act)
            qd_pkg::QD_ACT_UP:
            begin
                nxt_pos = pos_ff + POS_W'(1);
                nxt_up  = 1'b1;
            end
            qd_pkg::QD_ACT_DOWN:
            begin
                nxt_pos = pos_ff - POS_W'(1);
                nxt_dn  = 1'b1;
            end
            default:
            begin
                nxt_pos = pos_ff;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lvl_ff  <= 2'h0;
            prev_ff <= 2'h0;
            pos_ff  <= '0;
            up_ff   <= 1'b0;
            dn_ff   <= 1'b0;
        end
        else
        begin
            lvl_ff  <= phase;
            prev_ff <= nxt_prev;
            pos_ff  <= nxt_pos;
            up_ff   <= nxt_up;
            dn_ff   <= nxt_dn;
        end
    end

    assign step_increment = up_ff;
    assign step_decrement = dn_ff;
    assign position       = pos_ff;

    // -------------------------------------------------------------------------
    // interrupt flags
    // -------------------------------------------------------------------------
    logic       flag0_ff;
    logic       nxt_flag0;
    logic       flag1_ff;
    logic       nxt_flag1;
    logic [1:0] ev_ff;

    always_comb
    begin
        nxt_flag0 = flag0_ff;
        nxt_flag1 = flag1_ff;
        if (wr_en && (paddr == `QD_OFS_FLAG_LOW))
        begin
            nxt_flag0 = pwdata[`QD_BIT_CHAN0_FLAG];
        end
        if (wr_en && (paddr == `QD_OFS_FLAG_HIGH))
        begin
            nxt_flag1 = pwdata[`QD_BIT_CHAN1_FLAG];
        end
        // an edge in the clearing cycle still leaves its request pending
        nxt_flag0 = nxt_flag0 | det[0];
        nxt_flag1 = nxt_flag1 | det[1];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            flag0_ff <= 1'b0;
            flag1_ff <= 1'b0;
            ev_ff    <= 2'h0;
        end
        else
        begin
            flag0_ff <= nxt_flag0;
            flag1_ff <= nxt_flag1;
            ev_ff    <= det;
        end
    end

    assign chan0_edge_irq = ev_ff[0];
    assign chan1_edge_irq = ev_ff[1];
    assign irq            = (flag0_ff & ~mask0_ff) | (flag1_ff & ~mask1_ff);

    // -------------------------------------------------------------------------
    // read data
    // -------------------------------------------------------------------------
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;

    always_comb
    begin
        nxt_rdata = rdata_ff;
        if (rd_setup)
        begin
            case (paddr)
                `QD_OFS_FILTER_EN:   nxt_rdata = {30'h0, filt_en_ff};
                `QD_OFS_MASK_LOW:    nxt_rdata = {24'h0, mask0_ff, 7'h0};
                `QD_OFS_MASK_HIGH:   nxt_rdata = {24'h0, `QD_HIGH_FIXED_ONES | {7'h0, mask1_ff}};
                `QD_OFS_FLAG_LOW:    nxt_rdata = {24'h0, flag0_ff, 7'h0};
                `QD_OFS_FLAG_HIGH:   nxt_rdata = {24'h0, `QD_HIGH_FIXED_ONES | {7'h0, flag1_ff}};
                `QD_OFS_CHAN_STATUS: nxt_rdata = {30'h0, chan_en_ff};
                `QD_OFS_POSITION:    nxt_rdata = 32'(signed'(pos_ff));
                `QD_OFS_EDGE_SELECT: nxt_rdata = {28'h0, edge_sel_ff};
                default:             nxt_rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rdata_ff <= 32'h0;
        end
        else
        begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign prdata = rdata_ff;

    // -------------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_a_edge(logic [1:0] lv, logic dir);
        det == 2'h1 && prev_ff == lv && phase[0] == dir;
    endsequence

    sequence s_b_edge(logic [1:0] lv, logic dir);
        det == 2'h2 && prev_ff == lv && phase[1] == dir;
    endsequence

    sequence s_down;
        dn_ff && !up_ff && pos_ff == POS_W'($past(pos_ff) - POS_W'(1));
    endsequence

    sequence s_up;
        up_ff && !dn_ff && pos_ff == POS_W'($past(pos_ff) + POS_W'(1));
    endsequence

    a_mask_gates_irq: assert property (
        (flag0_ff && mask0_ff && (!flag1_ff || mask1_ff)) |-> !irq)
        else $error("masked request reached the interrupt output");

    a_start_sets_en: assert property (
        start_wr && pwdata[0] |=> chan_en_ff[0] ##1 chan_en_ff[0])
        else $error("start trigger did not enable channel 0");

    a_start_zero_noop: assert property (
        start_wr && pwdata[1:0] == 2'h0 |=> chan_en_ff == $past(chan_en_ff))
        else $error("start trigger zero changed channel state");

    a_flag_on_edge: assert property (
        det[1] |=> flag1_ff && chan1_edge_irq)
        else $error("channel 1 edge left no pending request");

    a_both_low_steps: assert property (
        (s_a_edge(2'h0, 1'b1) |=> s_down) and (s_b_edge(2'h0, 1'b1) |=> s_up))
        else $error("wrong step with both phases low");

    a_a_high_steps: assert property (
        (s_a_edge(2'h1, 1'b0) |=> s_up) and (s_b_edge(2'h1, 1'b1) |=> s_down))
        else $error("wrong step with only phase a high");

    a_b_high_steps: assert property (
        (s_a_edge(2'h2, 1'b1) |=> s_up) and (s_b_edge(2'h2, 1'b0) |=> s_down))
        else $error("wrong step with only phase b high");

    a_both_high_steps: assert property (
        (s_a_edge(2'h3, 1'b0) |=> s_down) and (s_b_edge(2'h3, 1'b0) |=> s_up))
        else $error("wrong step with both phases high");

    a_both_edge_sel: assert property (
        chan_en_ff[0] && edge_sel_ff[1] && phase[0] != lvl_ff[0] |-> det[0])
        else $error("both-edge channel missed an edge");

    a_prev_follows: assert property (
        det != 2'h0 |=> prev_ff == $past(phase))
        else $error("stored phase levels not updated after an edge");

    a_nomatch_hold: assert property (
        det != 2'h0 && !tbl_hit |=> pos_ff == $past(pos_ff) && !up_ff && !dn_ff)
        else $error("unmatched edge moved the position");

endmodule

// >>> tb/qd_encoder_model.sv
// behavioural two-phase encoder driving the decoder's phase inputs
`timescale 1ns/10ps

module qd_encoder_model
(
    input  wire logic       pclk,
    output      logic [1:0] enc_pins
);

    initial enc_pins = 2'h0;

    // ------------------------------------------------------------------------
    // one move: toggle the chosen phases, then hold the new levels
    // ------------------------------------------------------------------------
    // a real encoder holds its levels between moves, so idle lines stay put
    task automatic move(input logic [1:0] which, input int hold);
        @(posedge pclk);
        enc_pins <= enc_pins ^ which;
        repeat (hold) @(posedge pclk);
    endtask

endmodule

// >>> tb/qd_quad_decoder_tb.sv
// self-checking bench for the quadrature decoder
`timescale 1ns/10ps
`include "qd_cfg.svh"

module qd_quad_decoder_tb;

    localparam int SAMPLES = 3;

    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [1:0]  enc_pins;
    logic        chan0_edge_irq;
    logic        chan1_edge_irq;
    logic        step_increment;
    logic        step_decrement;
    logic [15:0] position;
    logic        irq;
    logic [31:0] rd;
    logic        err;
    logic        pa = 1'b0;
    logic        pb = 1'b0;
    int          num_errors = 0;
    int          checks = 0;
    int          exp_pos = 0, exp_up = 0, exp_dn = 0, exp_e0 = 0, exp_e1 = 0;
    int          seen_up = 0, seen_dn = 0, seen_e0 = 0, seen_e1 = 0;
    logic [7:0]  ra [9] = '{`QD_OFS_FILTER_EN, `QD_OFS_MASK_LOW, `QD_OFS_MASK_HIGH,
        `QD_OFS_START_TRIG, `QD_OFS_FLAG_LOW, `QD_OFS_FLAG_HIGH, `QD_OFS_CHAN_STATUS,
        `QD_OFS_POSITION, `QD_OFS_EDGE_SELECT};
    logic [31:0] rv [9] = '{32'h3, 32'h80, 32'hF9, 32'h0, 32'h0, 32'hF8, 32'h0, 32'h0, 32'hA};

    initial pclk = 1'b0;
    always #12.5 pclk = ~pclk;

    qd_quad_decoder #(.POS_W(16), .SAMPLES(SAMPLES)) i_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .encoder_input_pin(enc_pins),
        .chan0_edge_irq(chan0_edge_irq), .chan1_edge_irq(chan1_edge_irq),
        .step_increment(step_increment), .step_decrement(step_decrement),
        .position(position), .irq(irq));

    qd_encoder_model i_enc (.pclk(pclk), .enc_pins(enc_pins));

    // ------------------------------------------------------------------------
    // pulse counters
    // ------------------------------------------------------------------------
    always @(posedge pclk)
    begin
        seen_up += (step_increment === 1'b1);
        seen_dn += (step_decrement === 1'b1);
        seen_e0 += (chan0_edge_irq === 1'b1);
        seen_e1 += (chan1_edge_irq === 1'b1);
    end

    // ------------------------------------------------------------------------
    // checking and bus tasks
    // ------------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic final_report;
        $display("checks=%0d num_errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // setup cycle, then access until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // step sign: up bits of the table at indices 1, 2, 4 and 7
    function automatic int step_of(input logic a, input logic b, input logic mb);
        return ((8'h96 >> {b, a, mb}) & 8'h01) ? 1 : -1;
    endfunction

    task automatic expect_move(input logic [1:0] w);
        int st;
        st = (w == 2'h3) ? 0 : step_of(pa, pb, w[1]);
        exp_pos += st;
        exp_up  += (st > 0);
        exp_dn  += (st < 0);
        exp_e0  += w[0];
        exp_e1  += w[1];
        pa ^= w[0];
        pb ^= w[1];
    endtask

    task automatic settle_check;
        repeat (SAMPLES + 4) @(posedge pclk);
        chk({16'h0, position}, {16'h0, exp_pos[15:0]});
        chk(seen_up, exp_up);
        chk(seen_dn, exp_dn);
        chk(seen_e0, exp_e0);
        chk(seen_e1, exp_e1);
    endtask

    // random single-phase moves; a hold of 0 gives steps in consecutive cycles
    task automatic walk(input int n, input int min_hold);
        logic [1:0] w;
        for (int i = 0; i < n; i++)
        begin
            w = ($urandom % 2) ? 2'h2 : 2'h1;
            expect_move(w);
            i_enc.move(w, min_hold + $urandom_range(0, 3));
        end
        settle_check;
    endtask

    task automatic irq_is(input logic [31:0] exp);
        @(posedge pclk);
        chk({31'h0, irq}, exp);
    endtask

    // ------------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------------
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        presetn = 1'b0;
        void'($urandom(16463));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 9; i++)
        begin
            apb(1'b0, ra[i], 32'h0);
            chk(rd, rv[i]);
        end
        apb(1'b0, 8'h24, 32'h0);
        chk({31'h0, err}, 32'h1);
        i_enc.move(2'h1, 8);
        pa = 1'b1;
        apb(1'b0, `QD_OFS_FLAG_LOW, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, `QD_OFS_FILTER_EN, 32'h0);
        apb(1'b1, `QD_OFS_MASK_LOW, 32'h0);
        apb(1'b1, `QD_OFS_MASK_HIGH, 32'h0);
        apb(1'b1, `QD_OFS_FLAG_LOW, 32'h0);
        apb(1'b1, `QD_OFS_FLAG_HIGH, 32'h0);
        apb(1'b1, `QD_OFS_START_TRIG, 32'h1);
        apb(1'b1, `QD_OFS_START_TRIG, 32'h0);
        apb(1'b0, `QD_OFS_CHAN_STATUS, 32'h0);
        chk(rd, 32'h1);
        apb(1'b1, `QD_OFS_START_TRIG, 32'h2);
        apb(1'b0, `QD_OFS_CHAN_STATUS, 32'h0);
        chk(rd, 32'h3);
        apb(1'b1, `QD_OFS_POSITION, 32'h1234);
        walk(40, 0);
        apb(1'b0, `QD_OFS_POSITION, 32'h0);
        chk(rd, exp_pos);
        apb(1'b0, `QD_OFS_FLAG_LOW, 32'h0);
        chk(rd, 32'h80);
        apb(1'b0, `QD_OFS_FLAG_HIGH, 32'h0);
        chk(rd, 32'hF9);
        irq_is(32'h1);
        apb(1'b1, `QD_OFS_MASK_LOW, 32'h80);
        apb(1'b1, `QD_OFS_MASK_HIGH, 32'h1);
        irq_is(32'h0);
        apb(1'b1, `QD_OFS_MASK_HIGH, 32'h0);
        irq_is(32'h1);
        apb(1'b1, `QD_OFS_FLAG_HIGH, 32'h0);
        irq_is(32'h0);
        // one-cycle pulse on phase A: passes raw; then a two-cycle pulse is swallowed when filtered
        expect_move(2'h1);
        i_enc.move(2'h1, 0);
        expect_move(2'h1);
        i_enc.move(2'h1, 8);
        settle_check;
        apb(1'b1, `QD_OFS_FILTER_EN, 32'h3);
        i_enc.move(2'h1, 1);
        i_enc.move(2'h1, 8);
        settle_check;
        expect_move(2'h3);
        i_enc.move(2'h3, 8);
        settle_check;
        apb(1'b1, `QD_OFS_EDGE_SELECT, 32'hF);
        // single-edge codes: the first toggle is the ignored edge, the second finds
        // its phase back at the stored level, so it is flagged but gives no step
        repeat (2)
        begin
            apb(1'b1, `QD_OFS_EDGE_SELECT, {28'h0, 2'h3, 1'b0, pa});
            i_enc.move(2'h1, 8);
            i_enc.move(2'h1, 8);
            exp_e0++;
            settle_check;
            apb(1'b1, `QD_OFS_EDGE_SELECT, 32'hF);
            expect_move(2'h1);
            i_enc.move(2'h1, 8);
        end
        walk(30, SAMPLES + 1);
        final_report;
    end

    // a healthy run takes several hundred cycles
    initial
    begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        final_report;
    end

endmodule
